// file: core/ttx_exec.v
// Decode and execute unit for test-and-set, trap, logical test, xor and extract
`include "ttx_defines.vh"
// How it works
// RULE1 - test-and-set reads byte, T set if zero
// RULE2 - sets bit seven, writes byte back
// RULE3 - bus locked across read and write
// RULE4 - test-and-set: three cycles, four on variant
// RULE5 - trap immediate shifted two into code register
// RULE6 - trap saves pc and status
// RULE7 - trap sets mode, block, bank bits
// RULE8 - trap loads event code 0x160
// RULE9 - trap jumps to vector base plus 0x100
// RULE10 - trap in delay slot raises illegal slot
// RULE11 - trap: six cycles, eight on variant
// RULE12 - register test ANDs, sets T, one cycle
// RULE13 - immediate test with register zero
// RULE14 - memory test reads byte, three cycles
// RULE15 - register xor writes destination, T untouched
// RULE16 - immediate xor into register zero
// RULE17 - memory xor read-modify-write, three cycles
// RULE18 - extract middle 32 bits into destination
// RULE19 - non-trap instructions advance pc by two
module ttx_exec #(
  parameter DSP_VARIANT = 0
) (
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_reset,
  // Instruction issue
  input  wire        i_valid,
  input  wire [15:0] i_opcode,
  input  wire        i_delay_slot,
  output wire        o_ready,
  output reg         o_done,
  output reg         o_illegal_slot,
  // Register file read values
  input  wire [31:0] i_rn_val,
  input  wire [31:0] i_rm_val,
  input  wire [31:0] i_r0_val,
  // Register file write
  output reg         o_rf_we,
  output reg  [3:0]  o_rf_waddr,
  output reg  [31:0] o_rf_wdata,
  // Architectural state in
  input  wire [31:0] i_pc,
  input  wire [31:0] i_gbr,
  input  wire [31:0] i_vbr,
  // Architectural state out
  output reg  [31:0] o_pc,
  output reg  [31:0] o_status,
  output reg  [31:0] o_saved_pc,
  output reg  [31:0] o_saved_status,
  output reg  [31:0] o_trap_code,
  output reg  [11:0] o_exception_event,
  // Memory bus
  output reg         o_mem_req,
  output reg         o_mem_we,
  output reg  [31:0] o_mem_addr,
  output reg  [7:0]  o_mem_wdata,
  output reg         o_mem_lock,
  input  wire        i_mem_ack,
  input  wire [7:0]  i_mem_rdata
);
  localparam ST_IDLE  = 2'h0;
  localparam ST_READ  = 2'h1;
  localparam ST_WRITE = 2'h2;
  localparam ST_WAIT  = 2'h3;

  localparam [3:0] TAS_CYC  = DSP_VARIANT ? `TTX_CYC_TAS_DSP : `TTX_CYC_TAS;
  localparam [3:0] TRAP_CYC = DSP_VARIANT ? `TTX_CYC_TRAP_DSP : `TTX_CYC_TRAP;

  reg [1:0]  state_reg;
  reg [3:0]  cnt_reg;
  reg [1:0]  kind_reg;   // 0 tas, 1 logical_test_memory, 2 xor.b
  reg [7:0]  imm_reg;
  reg        wb_reg;
  reg [7:0]  byte_reg;
  reg        zero_reg;

  wire [3:0]  rn = i_opcode[11:8];
  wire [7:0]  imm = i_opcode[7:0];
  wire [15:0] hi  = i_opcode & `TTX_OP_HI_MASK;
  wire [15:0] rr  = i_opcode & `TTX_OP_RR_MASK;

  wire is_tas   = (i_opcode & `TTX_OP_TAS_MASK) == `TTX_OP_TAS_VAL;
  wire is_trap  = hi == `TTX_OP_TRAP;
  wire is_tsti  = hi == `TTX_OP_TSTI;
  wire is_tstm  = hi == `TTX_OP_TSTM;
  wire is_xori  = hi == `TTX_OP_XORI;
  wire is_xorm  = hi == `TTX_OP_XORM;
  wire is_tstrr = rr == `TTX_OP_TST_RR;
  wire is_xorrr = rr == `TTX_OP_XOR_RR;
  wire is_middle_extract = rr == `TTX_OP_MIDDLE_EXTRACT;

  wire [7:0] alu_result;
  wire       alu_zero;

  ttx_byte_alu u_alu (
    .i_data   (i_mem_rdata),
    .i_imm    (imm_reg),
    .i_sel    (kind_reg),
    .o_result (alu_result),
    .o_zero   (alu_zero)
  );

  assign o_ready = (state_reg == ST_IDLE);

  // Sequencer and architectural updates
  always @(posedge i_clk) begin
    if (i_reset) begin
      state_reg         <= ST_IDLE;
      cnt_reg           <= 4'h0;
      kind_reg          <= 2'h0;
      imm_reg           <= 8'h00;
      wb_reg            <= 1'b0;
      byte_reg          <= 8'h00;
      zero_reg          <= 1'b0;
      o_done            <= 1'b0;
      o_illegal_slot    <= 1'b0;
      o_rf_we           <= 1'b0;
      o_rf_waddr        <= 4'h0;
      o_rf_wdata        <= 32'h0000_0000;
      o_pc              <= 32'h0000_0000;
      o_status          <= 32'h0000_0000;
      o_saved_pc        <= 32'h0000_0000;
      o_saved_status    <= 32'h0000_0000;
      o_trap_code       <= 32'h0000_0000;
      o_exception_event <= 12'h000;
      o_mem_req         <= 1'b0;
      o_mem_we          <= 1'b0;
      o_mem_addr        <= 32'h0000_0000;
      o_mem_wdata       <= 8'h00;
      o_mem_lock        <= 1'b0;
    end else begin
      o_done         <= 1'b0;
      o_illegal_slot <= 1'b0;
      o_rf_we        <= 1'b0;
      if (cnt_reg != 4'h0)
        cnt_reg <= cnt_reg - 4'h1;
      case (state_reg)
        ST_IDLE: begin
          if (i_valid) begin
            if (is_trap && i_delay_slot) begin
              o_illegal_slot <= 1'b1;                        // [RULE10]
              o_done         <= 1'b1;
            end else if (is_trap) begin
              o_trap_code       <= {22'h00_0000, imm, 2'b00};  // [RULE5]
              o_saved_pc        <= i_pc;                      // [RULE6]
              o_saved_status    <= o_status;                  // [RULE6]
              o_status[`TTX_PRIVILEGED_MODE_BIT] <= 1'b1;                   // [RULE7]
              o_status[`TTX_EXCEPTION_BLOCK_BIT] <= 1'b1;                   // [RULE7]
              o_status[`TTX_BANK_SELECT_BIT] <= 1'b1;                   // [RULE7]
              o_exception_event <= `TTX_EXCEPTION_EVENT_REG_TRAP;          // [RULE8]
              o_pc              <= i_vbr + `TTX_TRAP_OFFSET;  // [RULE9]
              cnt_reg           <= TRAP_CYC - 4'h1;           // [RULE11]
              kind_reg          <= 2'h3;                      // Marks a trap in progress
              state_reg         <= ST_WAIT;
            end else if (is_tas || is_tstm || is_xorm) begin
              kind_reg   <= is_tas ? 2'h0 : (is_tstm ? 2'h1 : 2'h2);
              wb_reg     <= !is_tstm;                         // [RULE14]
              imm_reg    <= imm;
              o_mem_addr <= is_tas ? i_rn_val : i_gbr + i_r0_val;  // [RULE1] [RULE14] [RULE17]
              o_mem_req  <= 1'b1;
              o_mem_we   <= 1'b0;
              o_mem_lock <= is_tas;                           // [RULE3]
              cnt_reg    <= (is_tas ? TAS_CYC : `TTX_CYC_MEM) - 4'h1;  // [RULE4] [RULE14] [RULE17]
              state_reg  <= ST_READ;
            end else begin
              // Single-cycle register forms
              o_done <= 1'b1;
              o_pc   <= i_pc + `TTX_PC_STEP;                  // [RULE19]
              if (is_tstrr)
                o_status[`TTX_SR_T] <= ((i_rn_val & i_rm_val) == 32'h0000_0000);  // [RULE12]
              if (is_tsti)
                o_status[`TTX_SR_T] <= ((i_r0_val & {24'h00_0000, imm}) == 32'h0000_0000);  // [RULE13]
              if (is_xorrr) begin
                o_rf_we    <= 1'b1;
                o_rf_waddr <= rn;
                o_rf_wdata <= i_rn_val ^ i_rm_val;            // [RULE15]
              end
              if (is_xori) begin
                o_rf_we    <= 1'b1;
                o_rf_waddr <= 4'h0;
                o_rf_wdata <= i_r0_val ^ {24'h00_0000, imm};  // [RULE16]
              end
              if (is_middle_extract) begin
                o_rf_we    <= 1'b1;
                o_rf_waddr <= rn;
                o_rf_wdata <= {i_rm_val[15:0], i_rn_val[31:16]};  // [RULE18]
              end
            end
          end
        end
        ST_READ: begin
          if (i_mem_ack) begin
            byte_reg <= alu_result;
            zero_reg <= alu_zero;
            if (kind_reg != 2'h2)
              o_status[`TTX_SR_T] <= alu_zero;                // [RULE1] [RULE14]
            if (wb_reg) begin
              o_mem_we    <= 1'b1;
              o_mem_wdata <= alu_result;                      // [RULE2] [RULE17]
              state_reg   <= ST_WRITE;
            end else begin
              o_mem_req <= 1'b0;
              state_reg <= ST_WAIT;
            end
          end
        end
        ST_WRITE: begin
          if (i_mem_ack) begin
            o_mem_req  <= 1'b0;
            o_mem_we   <= 1'b0;
            o_mem_lock <= 1'b0;                               // [RULE3]
            state_reg  <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (cnt_reg <= 4'h1) begin
            o_done    <= 1'b1;
            state_reg <= ST_IDLE;
            // Trap keeps its vector target; memory forms step past the opcode
            if (kind_reg != 2'h3)
              o_pc <= i_pc + `TTX_PC_STEP;                    // [RULE19]
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule

// file: pkg/ttx_defines.vh
// Opcode patterns, status bit positions, codes and cycle counts for the trap/test/xor/extract unit
`ifndef TTX_DEFINES_VH
`define TTX_DEFINES_VH
`define TTX_OP_TAS_MASK   16'hF0FF
`define TTX_OP_TAS_VAL    16'h401B
`define TTX_OP_HI_MASK    16'hFF00
`define TTX_OP_TRAP       16'hC300
`define TTX_OP_TSTI       16'hC800
`define TTX_OP_TSTM       16'hCC00
`define TTX_OP_XORI       16'hCA00
`define TTX_OP_XORM       16'hCE00
`define TTX_OP_RR_MASK    16'hF00F
`define TTX_OP_TST_RR     16'h2008
`define TTX_OP_XOR_RR     16'h200A
`define TTX_OP_MIDDLE_EXTRACT      16'h200D
`define TTX_SR_T          0
`define TTX_EXCEPTION_BLOCK_BIT         28
`define TTX_BANK_SELECT_BIT         29
`define TTX_PRIVILEGED_MODE_BIT         30
`define TTX_EXCEPTION_EVENT_REG_TRAP   12'h0160
`define TTX_TRAP_OFFSET   32'h0000_0100
`define TTX_PC_STEP       32'h0000_0002
`define TTX_BYTE_MSB      8'h80
`define TTX_CYC_TAS       4'h3
`define TTX_CYC_TAS_DSP   4'h4
`define TTX_CYC_TRAP      4'h6
`define TTX_CYC_TRAP_DSP  4'h8
`define TTX_CYC_MEM       4'h3
`endif

// file: core/ttx_byte_alu.v
// Byte logic unit for memory test, xor and test-and-set
`include "ttx_defines.vh"
module ttx_byte_alu (
  // Operand and selection
  input  wire [7:0] i_data,
  input  wire [7:0] i_imm,
  input  wire [1:0] i_sel,
  // Results
  output reg  [7:0] o_result,
  output wire       o_zero
);
  reg [7:0] masked;

  // 0 test-and-set, 1 and-test, 2 xor
  always @* begin
    masked = (i_sel == 2'h0) ? i_data : (i_data & i_imm);
    case (i_sel)
      2'h0:    o_result = i_data | `TTX_BYTE_MSB;
      2'h2:    o_result = i_data ^ i_imm;
      default: o_result = i_data;
    endcase
  end

  assign o_zero = (masked == 8'h00);
endmodule

// file: sim/ttx_mem_model.sv
// Byte memory on the far side of the bus, with a settable wait
module ttx_mem_model (
  // Clock, reset and wait length
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic [3:0]  i_lat,
  // Bus from the core
  input  wire logic        i_req,
  input  wire logic        i_we,
  input  wire logic [31:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  output logic             o_ack,
  output logic [7:0]       o_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [16];
  logic [3:0] cnt_reg;
  // One ack per transfer after the wait; read data toggles when not valid
  always @(posedge i_clk) begin
    o_ack <= 1'b0;
    o_rdata <= ~o_rdata;
    cnt_reg <= (i_req && !o_ack) ? cnt_reg + 4'h1 : 4'h0;
    if (i_reset) begin
      cnt_reg <= 4'h0;
      o_rdata <= 8'h5a;
    end else if (i_req && !o_ack && cnt_reg >= i_lat) begin
      o_ack <= 1'b1;
      cnt_reg <= 4'h0;
      if (i_we) mem[i_addr[3:0]] <= i_wdata;
      else o_rdata <= mem[i_addr[3:0]];
    end
  end
endmodule

// file: sim/ttx_exec_monitor.sv
// Port-level assertions for the execute unit
module ttx_exec_monitor (
  // Watched ports
  input wire logic        i_clk, i_reset, i_valid, i_delay_slot, o_ready, o_done, o_illegal_slot,
  input wire logic        o_rf_we, o_mem_req, o_mem_we, o_mem_lock,
  input wire logic [15:0] i_opcode,
  input wire logic [31:0] i_rn_val, i_rm_val, i_pc, i_vbr, o_pc, o_status, o_saved_pc,
  input wire logic [31:0] o_trap_code, o_rf_wdata, o_mem_addr,
  input wire logic [11:0] o_exception_event
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  wire        take = o_ready && i_valid;
  wire [15:0] rr   = i_opcode & 16'hf00f;
  // Trap accepted outside a delay slot, then done after six cycles
  sequence trap_take;
    take && i_opcode[15:8] == 8'hc3 && !i_delay_slot;
  endsequence
  sequence trap_wait;
    !o_done [*5] ##1 o_done;
  endsequence
  rr_done_a: assert property (take && (rr == 16'h2008 || rr == 16'h200a) |=> o_done && o_pc == $past(i_pc) + 32'h2)
    else $error("register op late or pc wrong");
  xor_rr_a: assert property (take && rr == 16'h200a |=> o_rf_we && o_rf_wdata == $past(i_rn_val ^ i_rm_val))
    else $error("xor result wrong");
  middle_extract_mid_a: assert property (take && rr == 16'h200d |=> o_rf_wdata == {$past(i_rm_val[15:0]), $past(i_rn_val[31:16])})
    else $error("extract result wrong");
  trap_code_a: assert property (trap_take |=> o_trap_code == {22'h0, $past(i_opcode[7:0]), 2'h0} && o_exception_event == 12'h160)
    else $error("trap codes wrong");
  trap_save_a: assert property (trap_take |=> o_saved_pc == $past(i_pc) && o_status[30:28] == 3'h7 && o_pc == $past(i_vbr) + 32'h100)
    else $error("trap state wrong");
  trap_time_a: assert property (trap_take |=> trap_wait)
    else $error("trap length wrong");
  slot_refuse_a: assert property (take && i_opcode[15:8] == 8'hc3 && i_delay_slot |=> o_illegal_slot && o_done && $stable(o_pc))
    else $error("slot trap not refused");
  tas_lock_a: assert property (take && (i_opcode & 16'hf0ff) == 16'h401b |=> o_mem_req && o_mem_lock && !o_mem_we && o_mem_addr == $past(i_rn_val))
    else $error("test-and-set read wrong");
endmodule
bind ttx_exec ttx_exec_monitor u_mon (.*);

// file: sim/trap_test_xor_extract_exec_tb.sv
// Self-checking bench for the execute unit
module trap_test_xor_extract_exec_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_clk, i_reset, i_valid, i_delay_slot, i_mem_ack, o_ready, o_done, o_illegal_slot, o_rf_we;
  logic        o_mem_req, o_mem_we, o_mem_lock;
  logic [15:0] i_opcode;
  logic [31:0] i_rn_val, i_rm_val, i_r0_val, i_pc, i_gbr, i_vbr, o_pc, o_status, o_saved_pc, o_saved_status;
  logic [31:0] o_trap_code, o_rf_wdata, o_mem_addr, st, pc0;
  logic [11:0] o_exception_event;
  logic [7:0]  i_mem_rdata, o_mem_wdata;
  logic [3:0]  o_rf_waddr, lat;
  int          bad_count, n_checks, cyc, n;
  `define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; $display("unexpected %0t %h %h", $time, a, b); end end
  ttx_exec u_dut (.*);
  ttx_mem_model u_mem (.i_clk, .i_reset, .i_lat(lat), .i_req(o_mem_req), .i_we(o_mem_we), .i_addr(o_mem_addr),
    .i_wdata(o_mem_wdata), .o_ack(i_mem_ack), .o_rdata(i_mem_rdata));
  // Clock
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  // Hang guard
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Offer one opcode, then wait for completion; n is cycles after the take edge
  task automatic run(input logic [15:0] op, input logic ds, input logic [31:0] rn, rm, r0);
    i_opcode <= op;
    i_delay_slot <= ds;
    i_rn_val <= rn;
    i_rm_val <= rm;
    i_r0_val <= r0;
    i_valid <= 1'b1;
    @(posedge i_clk);
    i_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_done !== 1'b1 && n < 60);
  endtask
  // Register and immediate forms
  task automatic t_reg;
    run(16'h2108, 0, 32'h0f0f_0000, 32'hf0f0_ffff, 0);
    `CHK(o_status[0], 1'b1)
    `CHK(n, 1)
    run(16'h210a, 0, 32'h5555_5555, 32'haaaa_aaaa, 0);
    `CHK({o_rf_waddr, o_rf_wdata, o_status[0]}, {4'h1, 32'hffff_ffff, 1'b1})
    run(16'h210d, 0, 32'h89ab_cdef, 32'h0123_4567, 0);
    `CHK(o_rf_wdata, 32'h4567_89ab)
    `CHK(o_pc, 32'h0000_1002)
    run(16'hc8f0, 0, 0, 0, 32'h0000_0ff0);
    `CHK(o_status[0], 1'b0)
    run(16'hcaf0, 0, 0, 0, 32'hffff_ffff);
    `CHK({o_rf_waddr, o_rf_wdata}, {4'h0, 32'hffff_ff0f})
  endtask
  // Byte test-and-set, memory test and memory xor forms, prompt and slow memory
  task automatic t_mem;
    run(16'h431b, 0, 32'h0000_0003, 0, 0);
    `CHK({o_status[0], u_mem.mem[3]}, {1'b1, 8'h80})
    `CHK(n >= 3, 1'b1)
    lat <= 4'h3;
    run(16'h441b, 0, 32'h0000_0004, 0, 0);
    `CHK({o_status[0], u_mem.mem[4]}, {1'b0, 8'hc1})
    run(16'hcc5a, 0, 0, 0, 32'h0000_0002);
    `CHK({o_status[0], u_mem.mem[10]}, {1'b1, 8'ha5})
    run(16'hcea5, 0, 0, 0, 32'h0000_0002);
    `CHK(u_mem.mem[10], 8'h00)
  endtask
  // Trap refused in a delay slot, then taken
  task automatic t_trap;
    st = o_status;
    pc0 = o_pc;
    run(16'hc3ab, 1, 0, 0, 0);
    `CHK({o_illegal_slot, o_pc, o_status}, {1'b1, pc0, st})
    run(16'hc3ab, 0, 0, 0, 0);
    `CHK(n, 6)
    `CHK(o_trap_code, 32'h0000_02ac)
    `CHK({o_saved_pc, o_saved_status}, {i_pc, st})
    `CHK(o_status[30:28], 3'h7)
    `CHK(o_exception_event, 12'h160)
    `CHK(o_pc, 32'h8000_0100)
  endtask
  // Main sequence
  initial begin
    i_reset = 1'b1;
    i_valid = 1'b0;
    i_opcode = 16'h0009;
    i_delay_slot = 1'b0;
    i_rn_val = 32'h0;
    i_rm_val = 32'h0;
    i_r0_val = 32'h0;
    i_pc = 32'h0000_1000;
    i_gbr = 32'h0000_0008;
    i_vbr = 32'h8000_0000;
    lat = 4'h0;
    u_mem.mem[3] = 8'h00;
    u_mem.mem[4] = 8'h41;
    u_mem.mem[10] = 8'ha5;
    repeat (4) @(posedge i_clk);
    i_reset <= 1'b0;
    t_reg();
    t_mem();
    t_trap();
    print_verdict();
  end
endmodule
